/* verilog/ispr_pkg.sv */
// Shared constants for the interrupt source and priority block
package ispr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int PIN_N   = 8;
	localparam int PERI_N  = 21;
	localparam int SRC_N   = 30;
	localparam int SRC_W   = 5;
	localparam int VEC_W   = 7;
	localparam int ADDR_W  = 10;
	localparam int LVL_W   = 24;
	localparam int AXI_AW  = 8;
	localparam int AXI_DW  = 32;

	////////////////////////////////////////////////////////////////////////
	// Sense selection codes, two bits per pin
	localparam logic [1:0] SENSE_LOW  = 2'h0;
	localparam logic [1:0] SENSE_FALL = 2'h1;
	localparam logic [1:0] SENSE_RISE = 2'h2;
	localparam logic [1:0] SENSE_BOTH = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Vectors; the address is the vector shifted left by this amount
	localparam logic [VEC_W-1:0] VEC_NMI  = 7'h07;
	localparam logic [VEC_W-1:0] VEC_PIN0 = 7'h10;
	localparam int               VEC_ADDR_SHIFT = 2;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [AXI_AW-1:0] OFF_SYSCTL = 8'h00;
	localparam logic [AXI_AW-1:0] OFF_SENSE  = 8'h04;
	localparam logic [AXI_AW-1:0] OFF_ENABLE = 8'h08;
	localparam logic [AXI_AW-1:0] OFF_FLAGS  = 8'h0c;
	localparam logic [AXI_AW-1:0] OFF_LVL_A  = 8'h10;
	localparam logic [AXI_AW-1:0] OFF_LVL_B  = 8'h14;
	localparam logic [AXI_AW-1:0] OFF_LVL_C  = 8'h18;
	localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h1c;

	// Field positions and reset values
	localparam int          NMI_EDGE_BIT = 0;
	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [15:0] RST_SENSE    = 16'h0000;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Source table in ascending vector order: nmi, pins 0-7, watchdog,
	// refresh, address break, suspend, dma 0-3, timer 0, timer 1,
	// serial, usb. Level index points into {group c, group b, group a}.
	localparam logic [SRC_W-1:0] LVL_NONE = 5'h1f;

	localparam logic [VEC_W-1:0] SRC_VEC [SRC_N] = '{
		7'h07, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16,
		7'h17, 7'h19, 7'h1a, 7'h1b, 7'h1e, 7'h22, 7'h23, 7'h24,
		7'h25, 7'h40, 7'h41, 7'h42, 7'h44, 7'h45, 7'h46, 7'h50,
		7'h51, 7'h52, 7'h53, 7'h6c, 7'h6d, 7'h6e};

	localparam logic [SRC_W-1:0] SRC_LVL [SRC_N] = '{
		5'h1f, 5'h07, 5'h06, 5'h05, 5'h05, 5'h04, 5'h04, 5'h03,
		5'h03, 5'h01, 5'h00, 5'h1f, 5'h0e, 5'h0d, 5'h0d, 5'h0d,
		5'h0d, 5'h0b, 5'h0b, 5'h0b, 5'h0a, 5'h0a, 5'h0a, 5'h17,
		5'h17, 5'h17, 5'h17, 5'h10, 5'h10, 5'h10};

endpackage

/* verilog/ispr_pin_detect.sv */
// Pin synchroniser and sense detector for one request pin
`timescale 1ns/100ps
module ispr_pin_detect
	import ispr_pkg::*;
(
	input  logic       clock,
	input  logic       reset_n,
	input  logic       pin,
	input  logic [1:0] sense,
	output logic       hit,
	output logic       pin_high
);

	logic meta_r;
	logic sync_r;
	logic prev_r;

	// Two stages before anything looks at the pin; prev is the edge history
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// Sense decode; level mode repeats the hit every cycle while low
	always_comb begin
		unique case (sense)
			SENSE_LOW:  hit = !sync_r;
			SENSE_FALL: hit = prev_r && !sync_r;
			SENSE_RISE: hit = !prev_r && sync_r;
			SENSE_BOTH: hit = prev_r != sync_r;
		endcase
	end

	assign pin_high = sync_r;

endmodule

/* verilog/ispr_controller.sv */
// Interrupt source collection, pin flags and priority selection
`timescale 1ns/100ps
module ispr_controller
	import ispr_pkg::*;
(
	input  logic              clock,
	input  logic              reset_n,
	// AXI4-Lite register port
	input  logic [AXI_AW-1:0] s_axi_awaddr,
	input  logic              s_axi_awvalid,
	output logic              s_axi_awready,
	input  logic [AXI_DW-1:0] s_axi_wdata,
	input  logic [3:0]        s_axi_wstrb,
	input  logic              s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  logic              s_axi_bready,
	input  logic [AXI_AW-1:0] s_axi_araddr,
	input  logic              s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [AXI_DW-1:0] s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  logic              s_axi_rready,
	// Pins, active low request pins
	input  logic              nmi_pin,
	input  logic [PIN_N-1:0]  pin_request_n,
	// Peripheral requests, same clock
	input  logic [PERI_N-1:0] periph_flag,
	input  logic [PERI_N-1:0] periph_enable,
	// CPU side
	input  logic              cpu_ack,
	input  logic [VEC_W-1:0]  cpu_ack_vector,
	output logic              irq_valid,
	output logic [VEC_W-1:0]  irq_vector,
	output logic [ADDR_W-1:0] irq_address,
	output logic              irq_priority,
	output logic              irq_nmi,
	output logic              wake_request
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic                nmi_edge_select_r;
	logic [15:0]         pin_sense_selection_r;
	logic [PIN_N-1:0]    pin_request_enables_r;
	logic [PIN_N-1:0]    pin_request_flags_r;
	logic [PIN_N-1:0]    armed_r;
	logic [7:0]          level_bits_group_a_r;
	logic [7:0]          level_bits_group_b_r;
	logic [7:0]          level_bits_group_c_r;
	logic                nmi_pend_r;

	logic                awready_r;
	logic                wready_r;
	logic                bvalid_r;
	logic [1:0]          bresp_r;
	logic [AXI_AW-1:0]   aw_addr_r;
	logic [AXI_DW-1:0]   w_data_r;
	logic [3:0]          w_strb_r;
	logic                arready_r;
	logic                rvalid_r;
	logic [1:0]          rresp_r;
	logic [AXI_DW-1:0]   rdata_r;

	logic                irq_valid_r;
	logic [VEC_W-1:0]    irq_vector_r;
	logic [ADDR_W-1:0]   irq_address_r;
	logic                irq_priority_r;
	logic                irq_nmi_r;
	logic                wake_r;

	logic                wr_do;
	logic                rd_do;
	logic                wr_hit;
	logic [AXI_DW-1:0]   rd_data;
	logic                rd_hit;
	logic [PIN_N-1:0]    pin_hit;
	logic [PIN_N-1:0]    pin_high;
	logic                nmi_hit;
	logic [PIN_N-1:0]    sw_clr;
	logic [PIN_N-1:0]    exc_clr;
	logic [SRC_N-1:0]    src_req;
	logic [LVL_W-1:0]    levels;
	logic [SRC_W-1:0]    pick;
	logic                pick_lvl;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Word match, low two address bits ignored
	function automatic logic hit(input logic [AXI_AW-1:0] a,
		input logic [AXI_AW-1:0] off);
		hit = a[AXI_AW-1:2] == off[AXI_AW-1:2];
	endfunction

	// Byte lane merge under its strobe
	function automatic logic [7:0] merge8(input logic [7:0] old,
		input logic [7:0] data, input logic strb);
		merge8 = strb ? data : old;
	endfunction

	// Control level of a source; no level bit reads as level 0
	function automatic logic src_level(input int s,
		input logic [LVL_W-1:0] lv);
		src_level = 1'b0;
		if (SRC_LVL[s] != LVL_NONE) begin
			src_level = lv[SRC_LVL[s]];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus write channels; address and data taken in either order

	assign wr_do = !awready_r && !wready_r && !bvalid_r;
	assign wr_hit = hit(aw_addr_r, OFF_SYSCTL) || hit(aw_addr_r, OFF_SENSE)
		|| hit(aw_addr_r, OFF_ENABLE) || hit(aw_addr_r, OFF_FLAGS)
		|| hit(aw_addr_r, OFF_LVL_A) || hit(aw_addr_r, OFF_LVL_B)
		|| hit(aw_addr_r, OFF_LVL_C);

	// Ready comes back only after the response is taken: one write at a time
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			awready_r <= 1'b1;
			aw_addr_r <= '0;
		end else if (s_axi_awvalid && awready_r) begin
			awready_r <= 1'b0;
			aw_addr_r <= s_axi_awaddr;
		end else if (bvalid_r && s_axi_bready) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wready_r <= 1'b1;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (s_axi_wvalid && wready_r) begin
			wready_r <= 1'b0;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (bvalid_r && s_axi_bready) begin
			wready_r <= 1'b1;
		end
	end

	// Response the cycle after both halves are held
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_do) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			nmi_edge_select_r     <= 1'b0;
			pin_sense_selection_r <= RST_SENSE;
			pin_request_enables_r <= RST_BYTE;
			level_bits_group_a_r  <= RST_BYTE;
			level_bits_group_b_r  <= RST_BYTE;
			level_bits_group_c_r  <= RST_BYTE;
		end else if (wr_do) begin
			if (hit(aw_addr_r, OFF_SYSCTL) && w_strb_r[0]) begin
				nmi_edge_select_r <= w_data_r[NMI_EDGE_BIT];
			end
			if (hit(aw_addr_r, OFF_SENSE)) begin
				pin_sense_selection_r <= {
					merge8(pin_sense_selection_r[15:8],
						w_data_r[15:8], w_strb_r[1]),
					merge8(pin_sense_selection_r[7:0],
						w_data_r[7:0], w_strb_r[0])};
			end
			if (hit(aw_addr_r, OFF_ENABLE)) begin
				pin_request_enables_r <= merge8(pin_request_enables_r,
					w_data_r[7:0], w_strb_r[0]);
			end
			if (hit(aw_addr_r, OFF_LVL_A)) begin
				level_bits_group_a_r <= merge8(level_bits_group_a_r,
					w_data_r[7:0], w_strb_r[0]);
			end
			if (hit(aw_addr_r, OFF_LVL_B)) begin
				level_bits_group_b_r <= merge8(level_bits_group_b_r,
					w_data_r[7:0], w_strb_r[0]);
			end
			if (hit(aw_addr_r, OFF_LVL_C)) begin
				level_bits_group_c_r <= merge8(level_bits_group_c_r,
					w_data_r[7:0], w_strb_r[0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin detection; the pin is sampled whatever its port direction

	for (genvar i = 0; i < PIN_N; i++) begin : g_pin
		ispr_pin_detect u_det (
			.clock    (clock),
			.reset_n  (reset_n),
			.pin      (pin_request_n[i]),
			.sense    (pin_sense_selection_r[2*i +: 2]),
			.hit      (pin_hit[i]),
			.pin_high (pin_high[i])
		);
	end

	// NMI uses the same detector, limited to one of the two edges
	ispr_pin_detect u_nmi (
		.clock    (clock),
		.reset_n  (reset_n),
		.pin      (nmi_pin),
		.sense    (nmi_edge_select_r ? SENSE_RISE : SENSE_FALL),
		.hit      (nmi_hit),
		.pin_high ()
	);

	////////////////////////////////////////////////////////////////////////
	// Flag clearing terms

	// Software clear needs a prior read that saw the bit at 1
	always_comb begin
		sw_clr = '0;
		if (wr_do && hit(aw_addr_r, OFF_FLAGS) && w_strb_r[0]) begin
			sw_clr = armed_r & ~w_data_r[PIN_N-1:0];
		end
	end

	// Exception clear; not applied to a low-level pin that is still low, so its flag stays set
	always_comb begin
		exc_clr = '0;
		for (int i = 0; i < PIN_N; i++) begin
			if (cpu_ack && cpu_ack_vector == VEC_PIN0 + VEC_W'(i)
				&& (pin_sense_selection_r[2*i +: 2] != SENSE_LOW
				|| pin_high[i])) begin
				exc_clr[i] = 1'b1;
			end
		end
	end

	// Status flags; a detection in the clearing cycle wins
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_request_flags_r <= RST_BYTE;
		end else begin
			pin_request_flags_r <= (pin_request_flags_r
				& ~(sw_clr | exc_clr)) | pin_hit;
		end
	end

	// Read-as-one memory, dropped by any write to the flag word
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			armed_r <= RST_BYTE;
		end else if (wr_do && hit(aw_addr_r, OFF_FLAGS)) begin
			armed_r <= '0;
		end else if (rd_do && hit(s_axi_araddr, OFF_FLAGS)) begin
			armed_r <= armed_r | pin_request_flags_r;
		end
	end

	// NMI pending until the CPU takes vector 7
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			nmi_pend_r <= 1'b0;
		end else begin
			nmi_pend_r <= (nmi_pend_r
				&& !(cpu_ack && cpu_ack_vector == VEC_NMI)) || nmi_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Priority selection

	assign levels = {level_bits_group_c_r, level_bits_group_b_r,
		level_bits_group_a_r};
	assign src_req = {periph_flag & periph_enable,
		pin_request_flags_r & pin_request_enables_r,
		nmi_pend_r};

	// Scan downward so the last hit is the lowest vector of each level
	always_comb begin
		logic [SRC_W-1:0] best1;
		logic [SRC_W-1:0] best0;
		logic             found1;
		best1  = '0;
		best0  = '0;
		found1 = 1'b0;
		for (int s = SRC_N - 1; s > 0; s--) begin
			if (src_req[s] && src_level(s, levels)) begin
				best1  = SRC_W'(s);
				found1 = 1'b1;
			end else if (src_req[s]) begin
				best0 = SRC_W'(s);
			end
		end
		if (src_req[0]) begin
			pick = '0;
		end else if (found1) begin
			pick = best1;
		end else begin
			pick = best0;
		end
		pick_lvl = src_req[0] ? 1'b0 : found1;
	end

	// Registered request to the CPU; masking by the CPU is left to it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_valid_r    <= 1'b0;
			irq_vector_r   <= '0;
			irq_address_r  <= '0;
			irq_priority_r <= 1'b0;
			irq_nmi_r      <= 1'b0;
		end else begin
			irq_valid_r    <= |src_req;
			irq_vector_r   <= SRC_VEC[pick];
			irq_address_r  <= ADDR_W'(SRC_VEC[pick])
				<< VEC_ADDR_SHIFT;
			irq_priority_r <= pick_lvl;
			irq_nmi_r      <= src_req[0];
		end
	end

	// Standby wake from NMI or an enabled pin request
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wake_r <= 1'b0;
		end else begin
			wake_r <= |src_req[PIN_N:0];
		end
	end

	// Table order also fixes and see the package source table

	////////////////////////////////////////////////////////////////////////
	// Bus read channel

	assign rd_do = s_axi_arvalid && arready_r;

	// Read decode; status shows the current selection
	always_comb begin
		rd_data = '0;
		rd_hit  = 1'b1;
		if (hit(s_axi_araddr, OFF_SYSCTL)) begin
			rd_data[NMI_EDGE_BIT] = nmi_edge_select_r;
		end else if (hit(s_axi_araddr, OFF_SENSE)) begin
			rd_data[15:0] = pin_sense_selection_r;
		end else if (hit(s_axi_araddr, OFF_ENABLE)) begin
			rd_data[7:0] = pin_request_enables_r;
		end else if (hit(s_axi_araddr, OFF_FLAGS)) begin
			rd_data[7:0] = pin_request_flags_r;
		end else if (hit(s_axi_araddr, OFF_LVL_A)) begin
			rd_data[7:0] = level_bits_group_a_r;
		end else if (hit(s_axi_araddr, OFF_LVL_B)) begin
			rd_data[7:0] = level_bits_group_b_r;
		end else if (hit(s_axi_araddr, OFF_LVL_C)) begin
			rd_data[7:0] = level_bits_group_c_r;
		end else if (hit(s_axi_araddr, OFF_STATUS)) begin
			rd_data[10:0] = {irq_valid_r, irq_nmi_r, irq_priority_r,
				irq_vector_r, wake_r};
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rresp_r   <= RESP_OKAY;
			rdata_r   <= '0;
		end else if (rd_do) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= rd_hit ? RESP_OKAY : RESP_DECERR;
			rdata_r   <= rd_data;
		end else if (rvalid_r && s_axi_rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;
	assign irq_valid     = irq_valid_r;
	assign irq_vector    = irq_vector_r;
	assign irq_address   = irq_address_r;
	assign irq_priority  = irq_priority_r;
	assign irq_nmi       = irq_nmi_r;
	assign wake_request  = wake_r;

endmodule

/* sim/ispr_cpu_model.sv */
// CPU-side partner that takes offered vectors when allowed
`timescale 1ns/100ps
module ispr_cpu_model
	import ispr_pkg::*;
(
	input  logic             clock,
	input  logic             reset_n,
	input  logic             take_en,
	input  logic             irq_valid,
	input  logic [VEC_W-1:0] irq_vector,
	output logic             cpu_ack,
	output logic [VEC_W-1:0] cpu_ack_vector
);
	logic [1:0] gap_r;

	////////////////////////////////////////////////////////////////////////
	// One take pulse, then a pause: the block drops a taken request only
	// two cycles later, so an early second pulse would take it twice
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cpu_ack        <= 1'b0;
			cpu_ack_vector <= 7'h00;
			gap_r          <= 2'h0;
		end else if (take_en && irq_valid && gap_r == 2'h0) begin
			cpu_ack        <= 1'b1;
			cpu_ack_vector <= irq_vector;
			gap_r          <= 2'h3;
		end else begin
			cpu_ack        <= 1'b0;
			cpu_ack_vector <= ~irq_vector; // Junk while idle
			gap_r          <= (gap_r == 2'h0) ? 2'h0 : gap_r - 2'h1;
		end
	end
endmodule

/* sim/ispr_controller_chk.sv */
// Port checker for the interrupt source and priority block
`timescale 1ns/100ps
module ispr_controller_chk
	import ispr_pkg::*;
(
	input logic              clock,
	input logic              reset_n,
	input logic              s_axi_awvalid,
	input logic              s_axi_awready,
	input logic              s_axi_bvalid,
	input logic              s_axi_bready,
	input logic              s_axi_arvalid,
	input logic              s_axi_arready,
	input logic              s_axi_rvalid,
	input logic              s_axi_rready,
	input logic [AXI_DW-1:0] s_axi_rdata,
	input logic [PERI_N-1:0] periph_flag,
	input logic [PERI_N-1:0] periph_enable,
	input logic              irq_valid,
	input logic [VEC_W-1:0]  irq_vector,
	input logic [ADDR_W-1:0] irq_address,
	input logic              irq_priority,
	input logic              irq_nmi,
	input logic              wake_request
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////
	// Bus handshake steps
	sequence s_aw_taken;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	AST_WR_ANSWER: assert property (s_aw_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write answer missing");
	AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && !s_axi_awready) else $error("write answer lost");
	AST_RD_ANSWER: assert property (s_ar_taken |-> ##[1:2] s_axi_rvalid)
		else $error("read answer missing");
	AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");

	////////////////////////////////////////////////////////////////////////
	// Request selection
	AST_NMI_FIRST: assert property (
		irq_nmi |-> irq_valid && irq_vector == VEC_NMI && !irq_priority)
		else $error("nmi not selected");
	AST_VEC_ADDR: assert property (
		irq_valid |-> irq_address == {1'b0, irq_vector, 2'h0})
		else $error("vector address wrong");
	AST_PERI_GATE: assert property (
		irq_valid && !irq_nmi && irq_vector > 7'h17
		|-> $past(|(periph_flag & periph_enable))) else $error("peri ungated");
	AST_NMI_WAKE: assert property (irq_nmi |-> wake_request)
		else $error("nmi without wake");
	AST_PRIO_SRC: assert property (irq_priority |-> irq_valid && !irq_nmi)
		else $error("priority without source");
endmodule

bind ispr_controller ispr_controller_chk i_chk (.*);

/* sim/ispr_controller_tb_top.sv */
// Self-checking bench for the interrupt source and priority block
`timescale 1ns/100ps
module ispr_controller_tb_top
	import ispr_pkg::*;
();
	logic              clock, reset_n, nmi_pin, take_en, cpu_ack;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic              s_axi_rready, irq_valid, irq_priority, irq_nmi;
	logic              wake_request;
	logic [PIN_N-1:0]  pin_request_n;
	logic [PERI_N-1:0] periph_flag, periph_enable;
	logic [VEC_W-1:0]  cpu_ack_vector, irq_vector;
	logic [ADDR_W-1:0] irq_address;
	int                miscompares, checks;
	logic              late;   // Master holds ready back until the answer
	// Peripheral vectors in input bit order
	logic [6:0]        pvec [PERI_N] = '{7'h19, 7'h1a, 7'h1b, 7'h1e, 7'h22,
		7'h23, 7'h24, 7'h25, 7'h40, 7'h41, 7'h42, 7'h44, 7'h45, 7'h46,
		7'h50, 7'h51, 7'h52, 7'h53, 7'h6c, 7'h6d, 7'h6e};

	ispr_controller i_dut (.*);
	ispr_cpu_model  i_cpu (.*);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and waiting
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("Counts: %0d checks, %0d mismatches", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Bus cycles; each ends one edge after release so strobes never clash
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !late;
		for (int n = 0; n < 40 && !s_axi_bvalid; n++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		if (!s_axi_bvalid) begin
			miscompares++;
			stop_test();
		end
		// A late master raises ready now; the answer must still stand
		if (late) begin
			s_axi_bready <= 1'b1;
			@(posedge clock);
		end
		check(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
			input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !late;
		for (int n = 0; n < 40 && !s_axi_rvalid; n++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		if (!s_axi_rvalid) begin
			miscompares++;
			stop_test();
		end
		if (late) begin
			s_axi_rready <= 1'b1;
			@(posedge clock);
		end
		check(s_axi_rdata, ed);
		check(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{reset_n, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, take_en} = '0;
		late = 1'b0;
		{periph_flag, periph_enable, miscompares, checks} = '0;
		s_axi_wstrb = 4'hf;
		nmi_pin = 1'b1;
		pin_request_n = 8'hff;
		cyc(5);
		reset_n <= 1'b1;
		@(posedge clock);
		rd(OFF_SYSCTL, 32'h0, RESP_OKAY);
		rd(OFF_SENSE, 32'h0, RESP_OKAY);
		rd(OFF_ENABLE, 32'h0, RESP_OKAY);
		rd(OFF_LVL_A, 32'h0, RESP_OKAY);
		// Answers held by a slow master must not move
		late = 1'b1;
		rd(8'h40, 32'h0, RESP_DECERR);
		wr(OFF_STATUS, 32'h1, RESP_DECERR);
		late = 1'b0;
		$display("Test reset done");
		// Each sense code on pin 0, through a fall and a rise
		wr(OFF_ENABLE, 32'h1, RESP_OKAY);
		for (int c = 0; c < 4; c++) begin
			wr(OFF_SENSE, c, RESP_OKAY);
			pin_request_n[0] <= 1'b0;
			cyc(6);
			check({irq_valid, wake_request}, {2{c != 2}});
			rd(OFF_FLAGS, {31'h0, c != 2}, RESP_OKAY);
			wr(OFF_FLAGS, 32'h0, RESP_OKAY);
			rd(OFF_FLAGS, {31'h0, c == 0}, RESP_OKAY);
			pin_request_n[0] <= 1'b1;
			cyc(6);
			rd(OFF_FLAGS, {31'h0, c != 1}, RESP_OKAY);
			wr(OFF_FLAGS, 32'h0, RESP_OKAY);
			rd(OFF_FLAGS, 32'h0, RESP_OKAY);
		end
		$display("Test sense done");
		// Gating, default order and control levels
		wr(OFF_SENSE, 32'h14, RESP_OKAY);
		wr(OFF_ENABLE, 32'h0, RESP_OKAY);
		pin_request_n <= 8'hf9;
		cyc(6);
		check({irq_valid, wake_request}, 2'h0);
		rd(OFF_FLAGS, 32'h6, RESP_OKAY);
		// Ones never clear, and a zero with no read of one first neither
		wr(OFF_FLAGS, 32'hff, RESP_OKAY);
		wr(OFF_FLAGS, 32'h0, RESP_OKAY);
		rd(OFF_FLAGS, 32'h6, RESP_OKAY);
		wr(OFF_ENABLE, 32'h6, RESP_OKAY);
		rd(OFF_STATUS, 32'h423, RESP_OKAY);
		wr(OFF_LVL_A, 32'h20, RESP_OKAY);
		rd(OFF_STATUS, 32'h525, RESP_OKAY);
		periph_flag <= 21'h700;
		cyc(3);
		rd(OFF_STATUS, 32'h525, RESP_OKAY);
		periph_enable <= 21'h700;
		wr(OFF_LVL_B, 32'h8, RESP_OKAY);
		rd(OFF_STATUS, 32'h525, RESP_OKAY);
		wr(OFF_LVL_A, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, 32'h581, RESP_OKAY);
		$display("Test priority done");
		// NMI over everything, then the CPU takes all requests
		nmi_pin <= 1'b0;
		cyc(6);
		check({irq_nmi, irq_priority, irq_vector, irq_address},
			{2'h2, 7'h07, 10'h01c});
		periph_flag <= 21'h0;
		take_en <= 1'b1;
		cyc(20);
		check({irq_valid, irq_nmi}, 2'h0);
		rd(OFF_FLAGS, 32'h0, RESP_OKAY);
		wr(OFF_SYSCTL, 32'h1, RESP_OKAY);
		take_en <= 1'b0;
		nmi_pin <= 1'b1;
		cyc(6);
		check(irq_nmi, 1'b1);
		take_en <= 1'b1;
		cyc(6);
		take_en <= 1'b0;
		nmi_pin <= 1'b0;
		cyc(6);
		check({irq_valid, irq_nmi}, 2'h0);
		$display("Test nmi done");
		// Every peripheral source alone
		wr(OFF_LVL_B, 32'h0, RESP_OKAY);
		for (int i = 0; i < PERI_N; i++) begin
			periph_flag <= 21'h1 << i;
			periph_enable <= 21'h1 << i;
			cyc(3);
			check({irq_valid, irq_vector},
				{1'b1, pvec[i]});
		end
		periph_enable <= 21'h0;
		periph_flag <= 21'h1fffff;
		cyc(3);
		check(irq_valid, 1'b0);
		$display("Test peripheral done");
		stop_test();
	end
endmodule
